// ### asir_consts.svh
`ifndef ASIR_CONSTS_SVH
`define ASIR_CONSTS_SVH

// serial frame layout: 24 bits, MSB first
`define ASIR_FRAME_BITS 5'h18
`define ASIR_HDR_LAST 5'h0F
`define ASIR_ADDR_W 13
`define ASIR_RW_BIT 15

// register addresses
`define ASIR_ADR_MASK 13'h0071
`define ASIR_ADR_ID_LO 13'h0078
`define ASIR_ADR_ID_MID 13'h0079
`define ASIR_ADR_ID_HI 13'h007A
`define ASIR_ADR_ALARM 13'h007B
`define ASIR_ADR_STAT 13'h007D
`define ASIR_ADR_RSVD 13'h007F
`define ASIR_ADR_SEQ 13'h0091

// alarm mask / status field positions
`define ASIR_BIT_SYNCREQ 4
`define ASIR_BIT_PHASE 2
`define ASIR_BIT_SYSREF 1
`define ASIR_BIT_ALARM 0
`define ASIR_BIT_BUSY 4

// mask reset value and writable bits
`define ASIR_MASK_RST 8'h00
`define ASIR_MASK_WMASK 8'h16

`endif

// ### asir_pkg.sv
package asir_pkg;

  // sequencer step codes as read back by software
  typedef enum logic [3:0] {
    ASIR_RESET    = 4'h0,
    ASIR_DONE     = 4'h2,
    ASIR_READY0   = 4'h4,
    ASIR_READY1   = 4'h5,
    ASIR_READY2   = 4'h6,
    ASIR_RUNNING  = 4'hA,
    ASIR_START    = 4'hB,
    ASIR_PWRUP0   = 4'hC,
    ASIR_PWRUP1   = 4'hD,
    ASIR_PWRUP2   = 4'hE,
    ASIR_CLRRST   = 4'hF
  } asir_step_t;

  typedef struct packed {
    logic [7:0] mask;
    logic never_synced;
    logic alarm;
    logic busy;
    asir_step_t step;
    logic pulse_kind;
    logic sclk_q;
    logic [4:0] bit_cnt;
    logic [15:0] hdr;
    logic [7:0] wdata;
    logic [7:0] rdata;
    logic sdo;
    logic sdo_en;
  } asir_state_t;

endpackage

// ### asir_regs.sv
`timescale 1ns/1ps
`default_nettype none
`include "asir_consts.svh"

// Behaviour
// - mask bit 4 set lets the sync request condition raise the alarm.
// - mask bit 2 set lets output phase status raise the alarm.
// - mask bit 1 set lets SYSREF sync status raise the alarm.
// - combined alarm reads back as bit 0 of the alarm readback register.
// - fixed 24-bit identifier in three bytes, low, middle, high.
// - status bit 2 reads 1 when phase stable, 0 when not.
// - status bit 1 reads 0 after any sync, 1 if never synced.
// - sequencer status bit 4 reads 1 while any channel sequencer runs.
// - 4-bit step field reports sequencer step with the listed codes.
// - reseed and pulse triggers follow different progressions; running only for pulses.
module asir_regs #(
  parameter logic [23:0] PRODUCT_ID = 24'h00_5AA5 // arbitrary value
) (
  // clock and reset
  input wire logic CLK,
  input wire logic RST_B,
  // serial control port
  input wire logic SCLK,
  input wire logic SLEN_B,
  input wire logic SDIO_IN,
  output logic SDIO_OUT,
  output logic SDIO_OE,
  // status sources
  input wire logic SYNC_REQ_PENDING,
  input wire logic PHASE_STABLE,
  input wire logic SYNC_EVENT,
  input wire logic [13:0] CHAN_SEQ_ACTIVE,
  // sequencer triggers
  input wire logic RESEED_REQ,
  input wire logic PULSE_REQ,
  input wire logic PULSE_RUN,
  // results
  output logic ALARM,
  output logic [3:0] SEQ_STEP
);

  asir_pkg::asir_state_t st_r;
  asir_pkg::asir_state_t st_nxt;

  logic sclk_rise;
  logic sclk_fall;
  logic [12:0] addr;
  logic [7:0] rd_byte;

  function automatic logic [7:0] read_mux(input logic [12:0] a,
                                          input asir_pkg::asir_state_t s);
    logic [7:0] v;
    v = 8'h00;
    case (a)
      `ASIR_ADR_MASK: v = s.mask;
      `ASIR_ADR_ID_LO: v = PRODUCT_ID[7:0];
      `ASIR_ADR_ID_MID: v = PRODUCT_ID[15:8];
      `ASIR_ADR_ID_HI: v = PRODUCT_ID[23:16];
      `ASIR_ADR_ALARM: v[`ASIR_BIT_ALARM] = s.alarm;
      `ASIR_ADR_STAT: begin
        v[`ASIR_BIT_SYNCREQ] = SYNC_REQ_PENDING;
        v[`ASIR_BIT_PHASE] = PHASE_STABLE;
        v[`ASIR_BIT_SYSREF] = s.never_synced;
      end
      `ASIR_ADR_SEQ: begin
        v[`ASIR_BIT_BUSY] = s.busy;
        v[3:0] = s.step;
      end
      default: v = 8'h00;
    endcase
    return v;
  endfunction

  assign sclk_rise = SCLK & ~st_r.sclk_q;
  assign sclk_fall = ~SCLK & st_r.sclk_q;
  assign addr = st_r.hdr[`ASIR_ADDR_W-1:0];
  // a function result cannot be part-selected, so the byte gets its own net
  assign rd_byte = read_mux(addr, st_r);

  always_comb begin
    st_nxt = st_r;
    st_nxt.sclk_q = SCLK;

    // serial port: sample on rising edge, drive read data on falling edge
    if (SLEN_B) begin
      st_nxt.bit_cnt = 5'h00;
      st_nxt.sdo_en = 1'b0;
    end else begin
      if (sclk_rise && st_r.bit_cnt != `ASIR_FRAME_BITS) begin
        st_nxt.bit_cnt = st_r.bit_cnt + 5'h01;
        if (st_r.bit_cnt <= `ASIR_HDR_LAST) begin
          st_nxt.hdr = {st_r.hdr[14:0], SDIO_IN};
        end else begin
          st_nxt.wdata = {st_r.wdata[6:0], SDIO_IN};
        end
        // last data bit of a write frame commits it
        if (st_r.bit_cnt == `ASIR_FRAME_BITS - 5'h01 && !st_r.hdr[`ASIR_RW_BIT]
            && addr == `ASIR_ADR_MASK) begin
          st_nxt.mask = {st_r.wdata[6:0], SDIO_IN} & `ASIR_MASK_WMASK;
        end
      end
      if (sclk_fall && st_r.hdr[`ASIR_RW_BIT]) begin
        if (st_r.bit_cnt == `ASIR_HDR_LAST + 5'h01) begin
          // snapshot whole byte at once so the read is coherent
          st_nxt.rdata = {rd_byte[6:0], 1'b0};
          st_nxt.sdo = rd_byte[7];
          st_nxt.sdo_en = 1'b1;
        end else if (st_r.bit_cnt > `ASIR_HDR_LAST + 5'h01
                     && st_r.bit_cnt < `ASIR_FRAME_BITS) begin
          st_nxt.sdo = st_r.rdata[7];
          st_nxt.rdata = {st_r.rdata[6:0], 1'b0};
        end else if (st_r.bit_cnt == `ASIR_FRAME_BITS) begin
          st_nxt.sdo_en = 1'b0;
        end
      end
    end

    // never-synced flag falls on the first sync and stays low
    if (SYNC_EVENT) begin
      st_nxt.never_synced = 1'b0;
    end

    // combined alarm is active while any masked-in source is active, phase unstable being one
    st_nxt.alarm = (st_r.mask[`ASIR_BIT_SYNCREQ] & SYNC_REQ_PENDING)
                 | (st_r.mask[`ASIR_BIT_PHASE] & ~PHASE_STABLE)
                 | (st_r.mask[`ASIR_BIT_SYSREF] & st_r.never_synced);

    st_nxt.busy = |CHAN_SEQ_ACTIVE;

    // sequencer: one step per clock, pulse kind holds in running
    unique case (st_r.step)
      asir_pkg::ASIR_RESET: begin
        if (RESEED_REQ || PULSE_REQ) begin
          st_nxt.pulse_kind = PULSE_REQ & ~RESEED_REQ;
          st_nxt.step = asir_pkg::ASIR_PWRUP0;
        end
      end
      asir_pkg::ASIR_PWRUP0: st_nxt.step = asir_pkg::ASIR_PWRUP1;
      asir_pkg::ASIR_PWRUP1: st_nxt.step = asir_pkg::ASIR_PWRUP2;
      asir_pkg::ASIR_PWRUP2: begin
        st_nxt.step = st_r.pulse_kind ? asir_pkg::ASIR_START : asir_pkg::ASIR_CLRRST;
      end
      asir_pkg::ASIR_CLRRST: st_nxt.step = asir_pkg::ASIR_READY0;
      asir_pkg::ASIR_READY0: st_nxt.step = asir_pkg::ASIR_READY1;
      asir_pkg::ASIR_READY1: st_nxt.step = asir_pkg::ASIR_READY2;
      asir_pkg::ASIR_READY2: st_nxt.step = asir_pkg::ASIR_START;
      asir_pkg::ASIR_START: begin
        st_nxt.step = st_r.pulse_kind ? asir_pkg::ASIR_RUNNING : asir_pkg::ASIR_DONE;
      end
      asir_pkg::ASIR_RUNNING: begin
        if (!PULSE_RUN) begin
          st_nxt.step = asir_pkg::ASIR_DONE;
        end
      end
      asir_pkg::ASIR_DONE: st_nxt.step = asir_pkg::ASIR_RESET;
      default: st_nxt.step = asir_pkg::ASIR_RESET;
    endcase
  end

  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      st_r <= '0;
      st_r.mask <= `ASIR_MASK_RST;
      st_r.never_synced <= 1'b1;
      st_r.step <= asir_pkg::ASIR_RESET;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign SDIO_OUT = st_r.sdo;
  assign SDIO_OE = st_r.sdo_en;
  assign ALARM = st_r.alarm;
  assign SEQ_STEP = st_r.step;

endmodule
`default_nettype wire

// ### asir_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module asir_monitor (
  // watched ports
  input wire logic CLK,
  input wire logic RST_B,
  input wire logic SLEN_B,
  input wire logic SDIO_OE,
  input wire logic SYNC_REQ_PENDING,
  input wire logic PHASE_STABLE,
  input wire logic SYNC_EVENT,
  input wire logic RESEED_REQ,
  input wire logic PULSE_REQ,
  input wire logic PULSE_RUN,
  input wire logic ALARM,
  input wire logic [3:0] SEQ_STEP
);
  logic synced_r;
  default clocking @(posedge CLK);
  endclocking
  default disable iff (!RST_B);
  // own copy of the sync history, since the flag is not a port
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B)
      synced_r <= 1'b0;
    else if (SYNC_EVENT)
      synced_r <= 1'b1;
  end
  sequence pwr_up;
    SEQ_STEP == 4'hC ##1 SEQ_STEP == 4'hD ##1 SEQ_STEP == 4'hE;
  endsequence
  a_alarm_cause: assert property (
    ALARM |-> $past(SYNC_REQ_PENDING || !PHASE_STABLE || !synced_r)) else $error("alarm cause");
  a_step_legal: assert property (
    SEQ_STEP inside {4'h0, 4'h2, [4'h4:4'h6], [4'hA:4'hF]}) else $error("bad step");
  a_idle_wait: assert property (
    SEQ_STEP == 4'h0 && !RESEED_REQ && !PULSE_REQ |=> SEQ_STEP == 4'h0) else $error("idle");
  a_reseed_walk: assert property (
    SEQ_STEP == 4'h0 && RESEED_REQ |=> pwr_up ##1 SEQ_STEP == 4'hF ##1 SEQ_STEP == 4'h4
    ##1 SEQ_STEP == 4'h5 ##1 SEQ_STEP == 4'h6 ##1 SEQ_STEP == 4'hB ##1 SEQ_STEP == 4'h2)
    else $error("reseed walk");
  a_pulse_walk: assert property (
    SEQ_STEP == 4'h0 && PULSE_REQ && !RESEED_REQ |=> pwr_up ##1 SEQ_STEP == 4'hB
    ##1 SEQ_STEP == 4'hA) else $error("pulse walk");
  a_run_hold: assert property (
    SEQ_STEP == 4'hA && PULSE_RUN |=> SEQ_STEP == 4'hA) else $error("run hold");
  a_run_exit: assert property (
    SEQ_STEP == 4'hA && !PULSE_RUN |=> SEQ_STEP == 4'h2 ##1 SEQ_STEP == 4'h0) else $error("exit");
  a_oe_release: assert property (
    SLEN_B [*2] |-> !SDIO_OE) else $error("drive outside frame");
endmodule
bind asir_regs asir_monitor asir_monitor_i (.*);
`default_nettype wire

// ### asir_regs_tb.sv
`timescale 1ns/1ps
`default_nettype none
module asir_regs_tb;
  localparam logic [23:0] ID = 24'h12_3456; // arbitrary value
  logic CLK = 0, RST_B = 0, SCLK = 0, SLEN_B = 1, SDIO_IN = 0, SDIO_OUT, SDIO_OE, ALARM;
  logic SYNC_REQ_PENDING = 0, PHASE_STABLE = 1, SYNC_EVENT = 0, RESEED_REQ = 0;
  logic PULSE_REQ = 0, PULSE_RUN = 1;
  logic [13:0] CHAN_SEQ_ACTIVE = 14'h0000;
  logic [3:0] SEQ_STEP;
  logic [7:0] rd_r;
  logic oe_r = 0;
  int fails = 0, tests_run = 0;
  asir_regs #(.PRODUCT_ID(ID)) asir_regs_i (.*);
  initial forever #50 CLK = ~CLK;
  task tick(input int n);
    repeat (n) @(posedge CLK);
    #10;
  endtask
  task chk(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp) begin
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      fails++;
    end
  endtask
  // three clocks per half period keeps clear of the two-sample edge detect
  task xfer(input logic [23:0] f);
    SLEN_B = 0;
    for (int i = 0; i < 24; i++) begin
      SDIO_IN = f[23 - i];
      tick(3);
      SCLK = 1;
      if (i > 15)
        rd_r = {rd_r[6:0], SDIO_OUT};
      if (i == 16)
        oe_r = SDIO_OE;
      tick(3);
      SCLK = 0;
    end
    tick(3);
    SLEN_B = 1;
    tick(3);
  endtask
  task wr(input logic [12:0] a, input logic [7:0] d);
    xfer({3'h0, a, d});
  endtask
  task rd(input logic [12:0] a, input logic [7:0] e);
    xfer({3'h4, a, 8'h00});
    chk(rd_r, e);
    chk({7'h00, oe_r}, 8'h01);
    chk({7'h00, SDIO_OE}, 8'h00);
  endtask
  task al(input logic e);
    tick(2);
    chk({7'h00, ALARM}, {7'h00, e});
  endtask
  task seq(input logic [39:0] e, input int n);
    for (int i = n - 1; i >= 0; i--) begin
      tick(1);
      RESEED_REQ = 0;
      PULSE_REQ = 0;
      chk({4'h0, SEQ_STEP}, {4'h0, e[4 * i +: 4]});
    end
  endtask
  task t_id;
    rd(13'h0078, ID[7:0]);
    rd(13'h0079, ID[15:8]);
    rd(13'h007A, ID[23:16]);
    wr(13'h0078, 8'hFF);
    rd(13'h0078, ID[7:0]);
    rd(13'h007F, 8'h00);
    rd(13'h0071, 8'h00);
    $display("id test done");
  endtask
  task t_alarm;
    al(0);
    wr(13'h0071, 8'h02);
    al(1);
    rd(13'h007D, 8'h06);
    SYNC_EVENT = 1;
    tick(1);
    SYNC_EVENT = 0;
    al(0);
    rd(13'h007D, 8'h04);
    wr(13'h0071, 8'h04);
    PHASE_STABLE = 0;
    al(1);
    rd(13'h007B, 8'h01);
    rd(13'h007D, 8'h00);
    PHASE_STABLE = 1;
    al(0);
    wr(13'h0071, 8'hFF);
    rd(13'h0071, 8'h16);
    SYNC_REQ_PENDING = 1;
    al(1);
    wr(13'h0071, 8'h00);
    al(0);
    $display("alarm test done");
  endtask
  task t_seq;
    CHAN_SEQ_ACTIVE = 14'h2000;
    rd(13'h0091, 8'h10);
    CHAN_SEQ_ACTIVE = 14'h0000;
    rd(13'h0091, 8'h00);
    RESEED_REQ = 1;
    seq(40'hCD_EF45_6B20, 10);
    PULSE_REQ = 1;
    seq(40'h00_0CDE_BAAA, 7);
    PULSE_RUN = 0;
    seq(40'h00_0000_0020, 2);
    RESEED_REQ = 1;
    PULSE_REQ = 1;
    seq(40'hCD_EF45_6B20, 10);
    $display("sequencer test done");
  endtask
  task results;
    $display("fails %0d tests_run %0d", fails, tests_run);
    if (fails == 0 && tests_run > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  initial begin
    tick(20);
    RST_B = 1;
    tick(1);
    t_id;
    t_alarm;
    t_seq;
    results;
  end
  initial begin
    repeat (30000) @(posedge CLK);
    fails++;
    results;
  end
endmodule
`default_nettype wire
